// ==== verilog/tlc_pkg.sv ====
// Purpose: Shared constants for the top-level control register and its host
// Assumes: 16-bit host word bus, byte addresses with bit 0 unused
// Notes:   Everything on ref_clk (25 MHz)
package tlc_pkg;
    localparam int          ADDR_W            = 16;
    localparam int          DATA_W            = 16;
    localparam int          NUM_MODULES       = 5;
    // Device map
    localparam logic [15:0] TLC_OFFSET        = 16'h0000;
    localparam logic [15:0] TLC_RESET         = 16'h0000;
    localparam int          INTE_LSB          = 0;
    localparam int          RSVD_MSB          = 10;
    localparam int          RSVD_LSB          = 5;
    localparam logic [5:0]  RSVD_PATTERN      = 6'h20;
    localparam int          PAGE_BIT          = 11;
    localparam int          CLKSRC_MSB        = 13;
    localparam int          CLKSRC_LSB        = 12;
    localparam int          CLKMODE_BIT       = 14;
    localparam int          SWRES_BIT         = 15;
    // Reset hold time
    localparam int          CLK_MHZ           = 25;
    localparam int          RESET_HOLD_NS     = 2000;
    localparam int          RESET_HOLD_CYC    = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  RESET_HOLD_CNT    = 8'(RESET_HOLD_CYC);
    // Controller register map (word index times two)
    localparam logic [3:0]  CR_CTRL           = 4'h0;
    localparam logic [3:0]  CR_DATA           = 4'h2;
    localparam logic [3:0]  CR_RDATA          = 4'h4;
    localparam logic [3:0]  CR_STATUS         = 4'h6;
    localparam logic [3:0]  CR_EVENT          = 4'h8;
    localparam logic [3:0]  CR_MASK           = 4'ha;
    localparam logic [3:0]  CR_ADDR           = 4'hc;
    localparam int          CTRL_GO           = 0;
    localparam int          CTRL_WRITE        = 1;
    localparam int          CTRL_RESET        = 2;
    localparam logic [1:0]  EVT_RESET_RESET   = 2'h0;
    localparam logic [2:0]  CTRL_RESET_VAL    = 3'h0;

    typedef enum logic [1:0] {
        CLK_EXTERNAL = 2'h0,
        CLK_DIV2     = 2'h1,
        CLK_DIV4     = 2'h2,
        CLK_SECOND   = 2'h3
    } tlc_clksrc_t;

    typedef enum logic [3:0] {
        H_IDLE  = 4'h1,
        H_RESET = 4'h2,
        H_XFER  = 4'h4,
        H_DONE  = 4'h8
    } tlc_hstate_t;

    // Composes the control word so the reserved field is always correct
    function automatic logic [15:0] tlc_word(input logic [15:0] raw);
        logic [15:0] w;
        w = raw;
        w[RSVD_MSB:RSVD_LSB] = RSVD_PATTERN;
        w[PAGE_BIT] = 1'b1;
        return w;
    endfunction : tlc_word
endpackage : tlc_pkg

// ==== verilog/tlc_if.sv ====
`timescale 1ns/100ps
// Purpose: Host word bus between controller and device
// Assumes: One clock, strobes one cycle, read data the cycle after
// Notes:   Address is a byte address; bit 0 ignored
interface tlc_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        irq_n;

    modport dev  (input addr, input wdata, input wr, input rd, output rdata, output irq_n);
    modport host (output addr, output wdata, output wr, output rd, input rdata, input irq_n);
endinterface : tlc_if

// ==== verilog/tlc_device.sv ====
`timescale 1ns/100ps
// Purpose: Top-level control register, interrupt gate, clock selection, soft reset
// Assumes: Service requests and secondary clock come from other units
// Notes:   Clock outputs are registered levels of the ref_clk domain, high for one cycle or more
// What this block and its host do
// R1: Five module interrupt enables, bits 0 to 4
// R2: Interrupt when service request and enable
// R3: Host writes 100000 into bits 10:5
// R4: Host sets page bit 11 to one
// R5: Bits 13:12 choose primary transmit clock source
// R6: Mode bit zero substitutes clock divided by four
// R7: Host sets mode bit before reset release
// R8: Reset bit zero holds modules in reset
// R9: Host holds reset at least 2 us
// R10: Host releases software reset before other accesses
// R11: Register reads zero after reset
// R12: Word accesses only, byte addressed
// R13: Every bit reads back last write
module tlc_device
    import tlc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Host bus
    tlc_if.dev               bus,
    // Other units
    input  wire logic [4:0]  service_request,
    input  wire logic        secondary_cell_tx_clock,
    input  wire logic        ext_clock_in,
    // Clock and reset outputs
    output logic             primary_cell_tx_clock_o,
    output logic             primary_cell_tx_clock_oe,
    output logic             ext_clock_out,
    output logic             module_reset_n,
    output logic [1:0]       primary_tx_clock_source
);
    logic [15:0] top_level_control_reg;
    logic [15:0] rdata_reg;
    logic [1:0]  div_reg;
    logic [1:0]  sec_sync_reg;
    logic [1:0]  ext_sync_reg;
    logic        irq_n_reg;
    logic        pclk_reg;
    logic        eclk_reg;
    logic        sel_hit;

    // Bit 0 dropped: words only [R12]
    assign sel_hit = (bus.addr[15:1] == TLC_OFFSET[15:1]);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            top_level_control_reg <= TLC_RESET;                 // [R11]
        end else if (bus.wr && sel_hit) begin
            top_level_control_reg <= bus.wdata;                 // [R1] [R13]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 16'h0000;
        end else if (bus.rd) begin
            rdata_reg <= sel_hit ? top_level_control_reg : 16'h0000;  // [R13]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= ~|(service_request &
                top_level_control_reg[INTE_LSB +: NUM_MODULES]);   // [R2]
        end
    end

    // Pin clock inputs pass two flops first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_sync_reg <= 2'h0;
            ext_sync_reg <= 2'h0;
            div_reg      <= 2'h0;
        end else begin
            sec_sync_reg <= {sec_sync_reg[0], secondary_cell_tx_clock};
            ext_sync_reg <= {ext_sync_reg[0], ext_clock_in};
            div_reg      <= div_reg + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_reg <= 1'b0;
            eclk_reg <= 1'b0;
        end else begin
            case (tlc_clksrc_t'(top_level_control_reg[CLKSRC_MSB:CLKSRC_LSB]))  // [R5]
                CLK_DIV2:   pclk_reg <= div_reg[0];
                CLK_DIV4:   pclk_reg <= div_reg[1];
                CLK_SECOND: pclk_reg <= top_level_control_reg[CLKMODE_BIT] ?
                                        sec_sync_reg[1] : div_reg[1];   // [R6]
                default:    pclk_reg <= 1'b0;
            endcase
            // Substitute keeps blocks resettable with absent clocks
            eclk_reg <= top_level_control_reg[CLKMODE_BIT] ?
                        ext_sync_reg[1] : div_reg[1];           // [R6]
        end
    end

    assign bus.rdata                = rdata_reg;
    assign bus.irq_n                = irq_n_reg;
    assign primary_cell_tx_clock_o  = pclk_reg;
    assign primary_cell_tx_clock_oe =
        (top_level_control_reg[CLKSRC_MSB:CLKSRC_LSB] != CLK_EXTERNAL);   // [R5]
    assign ext_clock_out            = eclk_reg;
    assign module_reset_n           = top_level_control_reg[SWRES_BIT];   // [R8]
    assign primary_tx_clock_source  = top_level_control_reg[CLKSRC_MSB:CLKSRC_LSB];
endmodule : tlc_device

// ==== verilog/tlc_host.sv ====
`timescale 1ns/100ps
// Purpose: Host controller driving the device word bus from software orders
// Assumes: Software port: addr, wdata, wr, rd, rdata one cycle later
// Notes:   Reset sequence writes mode bit, then releases software reset
module tlc_host
    import tlc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Software port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [15:0]      sw_rdata,
    output logic             irq,
    // Device bus
    tlc_if.host              bus
);
    tlc_hstate_t state_reg;
    logic [7:0]  cnt_reg;
    logic [2:0]  ctrl_reg;
    logic [15:0] data_reg;
    logic [15:0] addr_reg;
    logic [15:0] rd_reg;
    logic [1:0]  evt_reg;
    logic [1:0]  mask_reg;
    logic [15:0] sw_rdata_reg;
    logic        dev_irq;
    logic        released_reg;
    logic        wr_reg;
    logic        rd_reg_s;
    logic [15:0] baddr_reg;
    logic [15:0] bdata_reg;
    logic        read_pend_reg;

    // Device interrupt is a ref_clk register, so no resync stages
    assign dev_irq = ~bus.irq_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET_VAL;
            data_reg <= 16'h0000;
            addr_reg <= 16'h0000;
            mask_reg <= 2'h0;
        end else if (sw_wr) begin
            if (sw_addr == CR_CTRL) ctrl_reg <= sw_wdata[2:0];
            else if (sw_addr == CR_DATA) data_reg <= sw_wdata;
            else if (sw_addr == CR_ADDR) addr_reg <= sw_wdata;
            else if (sw_addr == CR_MASK) mask_reg <= sw_wdata[1:0];
        end else if (state_reg != H_IDLE) begin
            ctrl_reg <= CTRL_RESET_VAL;
        end
    end

    // Event bits: 0 transfer done, 1 device interrupt; set wins over clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg <= EVT_RESET_RESET;
        end else begin
            evt_reg <= (evt_reg & ~((sw_wr && sw_addr == CR_EVENT) ? sw_wdata[1:0] : 2'h0))
                     | {dev_irq, state_reg == H_DONE};
        end
    end
    assign irq = |(evt_reg & mask_reg);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= H_IDLE;
            cnt_reg       <= 8'h00;
            wr_reg        <= 1'b0;
            rd_reg_s      <= 1'b0;
            baddr_reg     <= 16'h0000;
            bdata_reg     <= 16'h0000;
            released_reg  <= 1'b0;
            read_pend_reg <= 1'b0;
            rd_reg        <= 16'h0000;
        end else begin
            wr_reg        <= 1'b0;
            rd_reg_s      <= 1'b0;
            read_pend_reg <= rd_reg_s;
            if (read_pend_reg) rd_reg <= bus.rdata;
            case (state_reg)
                H_IDLE: begin
                    if (ctrl_reg[CTRL_RESET]) begin
                        // Register cleared: substitute clocks, modules held
                        wr_reg    <= 1'b1;
                        baddr_reg <= TLC_OFFSET;
                        bdata_reg <= tlc_word(16'h0000);          // [R3] [R4]
                        cnt_reg   <= RESET_HOLD_CNT;
                        state_reg <= H_RESET;
                    end else if (ctrl_reg[CTRL_GO] && released_reg) begin   // [R10]
                        wr_reg    <= ctrl_reg[CTRL_WRITE];
                        rd_reg_s  <= ~ctrl_reg[CTRL_WRITE];
                        baddr_reg <= {addr_reg[15:1], 1'b0};      // [R12]
                        bdata_reg <= (addr_reg[15:1] == TLC_OFFSET[15:1]) ?
                                     tlc_word(data_reg) : data_reg;   // [R3] [R4]
                        state_reg <= H_XFER;
                    end
                end
                H_RESET: begin
                    // Hold reset long enough, mode bit set first
                    cnt_reg <= cnt_reg - 8'h01;                   // [R9]
                    if (cnt_reg == 8'h02) begin
                        wr_reg    <= 1'b1;
                        bdata_reg <= tlc_word(16'h4000);          // [R7]
                    end else if (cnt_reg == 8'h00) begin
                        wr_reg       <= 1'b1;
                        bdata_reg    <= tlc_word(16'hc000);       // [R7] [R10]
                        released_reg <= 1'b1;
                        state_reg    <= H_DONE;
                    end
                end
                H_XFER: begin
                    state_reg <= H_DONE;
                end
                H_DONE: begin
                    if (!rd_reg_s && !read_pend_reg) state_reg <= H_IDLE;
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_rdata_reg <= 16'h0000;
        end else if (sw_rd) begin
            if (sw_addr == CR_CTRL) sw_rdata_reg <= {13'h0000, ctrl_reg};
            else if (sw_addr == CR_DATA) sw_rdata_reg <= data_reg;
            else if (sw_addr == CR_RDATA) sw_rdata_reg <= rd_reg;
            else if (sw_addr == CR_STATUS)
                sw_rdata_reg <= {13'h0000, dev_irq, released_reg, state_reg != H_IDLE};
            else if (sw_addr == CR_EVENT) sw_rdata_reg <= {14'h0000, evt_reg};
            else if (sw_addr == CR_MASK) sw_rdata_reg <= {14'h0000, mask_reg};
            else if (sw_addr == CR_ADDR) sw_rdata_reg <= addr_reg;
            else sw_rdata_reg <= 16'h0000;
        end
    end

    assign sw_rdata  = sw_rdata_reg;
    assign bus.addr  = baddr_reg;
    assign bus.wdata = bdata_reg;
    assign bus.wr    = wr_reg;
    assign bus.rd    = rd_reg_s;
endmodule : tlc_host

// ==== tb/tlc_sva.sv ====
// Purpose: Checker on the host word bus between controller and device
// Assumes: Only the bus signals are visible; register mirrored from writes
// Notes:   Offset 0 is matched with bit 0 of the address ignored
`timescale 1ns/100ps
module tlc_sva
    import tlc_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Host word bus
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        irq_n
);
    logic [15:0] shadow_reg;
    logic [7:0]  held_reg;
    logic        hit;

    assign hit = (addr[15:1] == 15'h0000);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) shadow_reg <= 16'h0000;
        else if (wr && hit) shadow_reg <= wdata;
    end
    // Saturates so a long run never wraps back under the hold time
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) held_reg <= 8'h00;
        else if (held_reg != 8'hff) held_reg <= held_reg + 8'h01;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_reg_read;
        rd && hit;
    endsequence
    sequence s_release;
        wr && hit && wdata[15] && !shadow_reg[15];
    endsequence

    chk_reg_readback: assert property (s_reg_read |=> rdata == $past(shadow_reg))
        else $error("register read differs from last write");
    chk_unmapped_zero: assert property (rd && !hit |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_reset_quiet: assert property (held_reg < 8'h02 |-> rdata == 16'h0000 && irq_n)
        else $error("bus not quiet after reset");
    chk_rsvd_fixed: assert property (wr && hit |-> wdata[10:5] == RSVD_PATTERN && wdata[11])
        else $error("fixed field written wrongly");
    chk_mode_first: assert property (s_release |-> wdata[14] && shadow_reg[14])
        else $error("released before clock mode set");
    chk_release_first: assert property ((wr || rd) && !hit |-> shadow_reg[15])
        else $error("access before software reset release");
    chk_hold_time: assert property (s_release |-> held_reg >= RESET_HOLD_CNT)
        else $error("software reset released too early");
    chk_strobe_single: assert property ((wr || rd) |-> !(wr && rd) ##1 !wr && !rd)
        else $error("strobe overlap or longer than one cycle");
    chk_irq_gate: assert property (!irq_n |-> $past(shadow_reg[4:0]) != 5'h00)
        else $error("interrupt with all enables clear");
endmodule : tlc_sva

// ==== tb/tb_main_control_register.sv ====
// Purpose: Bench for host controller and control register together
// Assumes: ext_clock_in held low; device reached through software port
// Notes:   Fixed field 10:5 = 100000 and bit 11 give 0c00 in every word
`timescale 1ns/100ps
module tb_main_control_register
    import tlc_pkg::*;
;
    localparam logic [15:0] FIX = 16'h0c00;
    logic        ref_clk, rst_n, sw_wr, sw_rd, irq, sec_clk, pclk, pclk_oe, ext_out, mrst_n;
    logic [3:0]  sw_addr;
    logic [15:0] sw_wdata, sw_rdata, d;
    logic [4:0]  sreq;
    logic [1:0]  src;
    int          n_mismatch = 0, n_compared = 0, n, k;

    tlc_if bus_if ();
    tlc_device tlc_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if),
        .service_request(sreq), .secondary_cell_tx_clock(sec_clk), .ext_clock_in(1'b0),
        .primary_cell_tx_clock_o(pclk), .primary_cell_tx_clock_oe(pclk_oe),
        .ext_clock_out(ext_out), .module_reset_n(mrst_n), .primary_tx_clock_source(src));
    tlc_host tlc_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .irq(irq), .bus(bus_if));
    tlc_sva tlc_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
        .irq_n(bus_if.irq_n));

    task automatic stop_test;
        $display("counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic bad(input string m);
        n_mismatch++;
        $display("BAD %0t %s", $time, m);
    endtask : bad

    task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string m);
        n_compared++;
        if (g !== e) bad(m);
    endtask : cmp

    task automatic swr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        sw_addr  <= a;
        sw_wdata <= v;
        sw_wr    <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : swr

    task automatic srd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask : srd

    // Device access through the controller; done flag polled, not timed
    task automatic xfer(input logic [15:0] a, input logic [15:0] v, input logic w,
                        output logic [15:0] r);
        int i;
        swr(CR_EVENT, 16'h0001);
        swr(CR_ADDR, a);
        swr(CR_DATA, v);
        swr(CR_CTRL, {14'h0000, w, 1'b1});
        r = 16'h0000;
        for (i = 0; i < 40 && r[0] !== 1'b1; i++) srd(CR_EVENT, r);
        if (r[0] !== 1'b1) begin
            bad("transfer hang");
            stop_test();
        end
        srd(CR_RDATA, r);
    endtask : xfer

    task automatic cnt(input bit e, output int c);
        c = 0;
        repeat (40) begin
            @(posedge ref_clk);
            #1 c += int'(e ? ext_out : pclk);
        end
    endtask : cnt

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Secondary clock is free running and unrelated to ref_clk
    initial begin
        sec_clk = 1'b0;
        forever #63 sec_clk = ~sec_clk;
    end

    initial begin
        rst_n = 1'b0;
        sw_addr = 4'h0;
        sw_wdata = 16'h0000;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        sreq = 5'h00;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        cmp(mrst_n, 16'h0000, "modules not held");
        cmp({pclk_oe, src}, 16'h0000, "clock select not zero");
        swr(CR_CTRL, 16'h0004);
        d = 16'h0000;
        for (n = 0; n < 100 && d[1] !== 1'b1; n++) srd(CR_STATUS, d);
        if (d[1] !== 1'b1) begin
            bad("release hang");
            stop_test();
        end
        cmp(mrst_n, 16'h0001, "modules still held");
        xfer(16'h0000, 16'h0000, 1'b0, d);
        cmp(d, 16'hc000 | FIX, "word after start-up");
        $display("test startup done");
        for (n = 0; n < 4; n++) begin
            xfer(16'h0000, 16'hc000 | (16'(n) << 12), 1'b1, d);
            xfer(16'h0001, 16'h0000, 1'b0, d);
            cmp(d, 16'hc000 | FIX | (16'(n) << 12), "readback");
            cmp({src, pclk_oe}, {13'h0000, 2'(n), n != 0}, "clock select");
            cnt(1'b0, k);
            if (n == 0) cmp(16'(k), 16'h0000, "clock driven while external");
            if (n == 1) cmp(16'(k), 16'h0014, "half rate clock");
            if (n == 2) cmp(16'(k), 16'h0014, "quarter rate clock");
            if (n == 3) cmp(16'(k != 0), 16'h0001, "clock idle");
        end
        xfer(16'h0000, 16'h8000, 1'b1, d);
        cnt(1'b1, k);
        cmp(16'(k), 16'h0014, "no substitute clock");
        xfer(16'h0000, 16'hc000, 1'b1, d);
        cnt(1'b1, k);
        cmp(16'(k), 16'h0000, "substitute clock kept");
        $display("test clocks done");
        swr(CR_MASK, 16'h0002);
        for (n = 0; n < 5; n++) begin
            xfer(16'h0000, 16'hc000 | 16'(1 << n), 1'b1, d);
            @(posedge ref_clk) sreq <= 5'(1 << n);
            repeat (3) @(posedge ref_clk);
            #1 cmp({bus_if.irq_n, irq}, 16'h0001, "enabled request lost");
            @(posedge ref_clk) sreq <= ~5'(1 << n);
            repeat (3) @(posedge ref_clk);
            #1 cmp(bus_if.irq_n, 16'h0001, "disabled request passed");
        end
        @(posedge ref_clk) sreq <= 5'h00;
        swr(CR_MASK, 16'h0000);
        #1 cmp(irq, 16'h0000, "masked interrupt");
        swr(CR_MASK, 16'h0002);
        #1 cmp(irq, 16'h0001, "sticky event lost");
        swr(CR_EVENT, 16'h0002);
        #1 cmp(irq, 16'h0000, "event not cleared");
        $display("test interrupts done");
        xfer(16'h0002, 16'h1234, 1'b1, d);
        xfer(16'h0002, 16'h0000, 1'b0, d);
        cmp(d, 16'h0000, "unmapped read");
        xfer(16'h0000, 16'h0000, 1'b0, d);
        cmp(d, 16'hc010 | FIX, "unmapped write landed");
        xfer(16'h0000, 16'h4000, 1'b1, d);
        cmp(mrst_n, 16'h0000, "software reset ignored");
        xfer(16'h0000, 16'hc000, 1'b1, d);
        cmp(mrst_n, 16'h0001, "software release ignored");
        $display("test refusals done");
        stop_test();
    end
endmodule : tb_main_control_register
